// ==== embi_bus.sv ====
// External memory bus interface with hold, bus request and external DMA slave path.
module embi_bus
    import embi_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [1:0] req_space,
    input wire logic req_write,
    input wire logic [EMBI_AW-1:0] req_addr,
    input wire logic [EMBI_DW-1:0] req_wdata,
    output logic rsp_valid,
    output logic [EMBI_DW-1:0] rsp_rdata,
    input wire logic instruction_acquire_n,
    input wire logic output_off_n,
    input wire logic hold_request_n,
    input wire logic ready_in,
    output logic hold_acknowledge_n,
    output logic hold_acknowledge_n_oe,
    input wire logic [EMBI_AW-1:0] address_lines_in,
    output logic [EMBI_AW-1:0] address_lines_out,
    output logic address_lines_oe,
    input wire logic [EMBI_DW-1:0] data_lines_in,
    output logic [EMBI_DW-1:0] data_lines_out,
    output logic data_lines_oe,
    output logic program_space_select_n,
    output logic data_space_select_n,
    output logic io_space_select_n,
    output logic space_select_oe,
    input wire logic read_write_in,
    output logic read_write_out,
    output logic read_write_oe,
    input wire logic bus_cycle_strobe_n_in,
    output logic bus_cycle_strobe_n_out,
    output logic bus_cycle_strobe_n_oe,
    output logic read_select_n,
    output logic read_select_n_oe,
    output logic write_enable_n,
    output logic write_enable_n_oe,
    input wire logic bus_request_n_in,
    output logic bus_request_n_out,
    output logic bus_request_n_oe
);
    logic ready_s;
    logic hold_n_s;
    logic off_n_s;
    logic br_n_s;
    logic bus_cycle_strobe_n_n_s;
    logic rw_s;
    logic iaq_n_s;

    embi_sync #(.RST_VAL(1'b0)) u_sync_ready (.clock(clock), .rstn(rstn), .din(ready_in), .dout(ready_s));
    embi_sync #(.RST_VAL(1'b1)) u_sync_hold (.clock(clock), .rstn(rstn), .din(hold_request_n), .dout(hold_n_s));
    embi_sync #(.RST_VAL(1'b1)) u_sync_off (.clock(clock), .rstn(rstn), .din(output_off_n), .dout(off_n_s));
    embi_sync #(.RST_VAL(1'b1)) u_sync_br (.clock(clock), .rstn(rstn), .din(bus_request_n_in), .dout(br_n_s));
    embi_sync #(.RST_VAL(1'b1)) u_sync_bus_cycle_strobe_n (.clock(clock), .rstn(rstn), .din(bus_cycle_strobe_n_in), .dout(bus_cycle_strobe_n_n_s));
    embi_sync #(.RST_VAL(1'b1)) u_sync_rw (.clock(clock), .rstn(rstn), .din(read_write_in), .dout(rw_s));
    embi_sync #(.RST_VAL(1'b1)) u_sync_iaq (.clock(clock), .rstn(rstn), .din(instruction_acquire_n), .dout(iaq_n_s));

    logic [EMBI_DW-1:0] ram [0:EMBI_RAM_WORDS-1];

    embi_state_t state_r, state_nxt;
    logic [1:0] space_r, space_nxt;
    logic write_r, write_nxt;
    logic [EMBI_AW-1:0] addr_r, addr_nxt;
    logic [EMBI_DW-1:0] wdata_r, wdata_nxt;
    logic [EMBI_DW-1:0] rdata_r, rdata_nxt;
    logic rsp_r, rsp_nxt;
    logic bus_cycle_strobe_n_prev_r, bus_cycle_strobe_n_prev_nxt;
    logic [EMBI_DW-1:0] dma_rdata_r, dma_rdata_nxt;
    logic dma_drive_r, dma_drive_nxt;
    logic rdy_low_r, rdy_low_nxt;

    logic in_hold;
    logic dma_active;
    logic dma_strobe;
    logic dma_hit;
    logic [EMBI_RAM_AW-1:0] dma_idx;

    assign in_hold = (state_r == EMBI_HOLD);
    // External DMA is possible only while the bus is released.
    assign dma_active = in_hold && !br_n_s;
    assign dma_strobe = dma_active && !iaq_n_s && bus_cycle_strobe_n_prev_r && !bus_cycle_strobe_n_n_s;
    assign dma_idx = address_lines_in[EMBI_RAM_AW-1:0];
    assign dma_hit = (address_lines_in < EMBI_AW'(EMBI_RAM_WORDS));

    always_comb
    begin
        state_nxt = state_r;
        space_nxt = space_r;
        write_nxt = write_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        rdata_nxt = rdata_r;
        rsp_nxt = 1'b0;
        bus_cycle_strobe_n_prev_nxt = bus_cycle_strobe_n_n_s;
        dma_rdata_nxt = dma_rdata_r;
        dma_drive_nxt = dma_active && !iaq_n_s && rw_s && !bus_cycle_strobe_n_n_s;
        // Ready counts only once it has been seen low in this cycle, so a level still in the synchroniser
        // from the previous cycle cannot end the new one early.
        rdy_low_nxt = (state_r == EMBI_ADDR || state_r == EMBI_STROBE) && (rdy_low_r || !ready_s);
        unique case (state_r)
            EMBI_IDLE:
            begin
                if (!hold_n_s)
                begin
                    state_nxt = EMBI_HOLD;
                end
                else if (req_valid)
                begin
                    space_nxt = req_space;
                    write_nxt = req_write;
                    addr_nxt = req_addr;
                    wdata_nxt = req_wdata;
                    state_nxt = EMBI_ADDR;
                end
            end
            EMBI_ADDR:
            begin
                state_nxt = EMBI_STROBE;
            end
            EMBI_STROBE:
            begin
                // Ready low stretches the cycle by one and is sampled again; it is the grant after a bus request.
                if (ready_s && rdy_low_r)
                begin
                    rdata_nxt = write_r ? rdata_r : data_lines_in;
                    rsp_nxt = 1'b1;
                    state_nxt = EMBI_DONE;
                end
            end
            EMBI_DONE:
            begin
                state_nxt = EMBI_IDLE;
            end
            EMBI_HOLD:
            begin
                if (hold_n_s)
                begin
                    state_nxt = EMBI_IDLE;
                end
                if (dma_strobe && dma_hit && rw_s)
                begin
                    dma_rdata_nxt = ram[dma_idx];
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            state_r <= EMBI_IDLE;
            space_r <= EMBI_SP_PROG;
            write_r <= 1'b0;
            addr_r <= EMBI_ADDR_RST;
            wdata_r <= EMBI_DATA_RST;
            rdata_r <= EMBI_DATA_RST;
            rsp_r <= 1'b0;
            bus_cycle_strobe_n_prev_r <= 1'b1;
            dma_rdata_r <= EMBI_DATA_RST;
            dma_drive_r <= 1'b0;
            rdy_low_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            space_r <= space_nxt;
            write_r <= write_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            rdata_r <= rdata_nxt;
            rsp_r <= rsp_nxt;
            bus_cycle_strobe_n_prev_r <= bus_cycle_strobe_n_prev_nxt;
            dma_rdata_r <= dma_rdata_nxt;
            dma_drive_r <= dma_drive_nxt;
            rdy_low_r <= rdy_low_nxt;
        end
    end

    // The RAM array has no reset, so it sits in a clocked process of its own.
    always_ff @(posedge clock)
    begin
        if (state_r == EMBI_HOLD && dma_strobe && dma_hit && !rw_s)
        begin
            ram[dma_idx] <= data_lines_in;
        end
    end

    logic cyc;
    logic bus_on;
    assign cyc = (state_r == EMBI_ADDR) || (state_r == EMBI_STROBE) || (state_r == EMBI_DONE);
    assign bus_on = off_n_s && !in_hold;

    assign req_ready = (state_r == EMBI_IDLE) && hold_n_s;
    assign rsp_valid = rsp_r;
    assign rsp_rdata = rdata_r;

    assign hold_acknowledge_n = !in_hold;
    assign hold_acknowledge_n_oe = off_n_s;

    // Address and controls are held from the registered copy across every wait cycle.
    assign address_lines_out = addr_r;
    assign address_lines_oe = bus_on;

    assign data_lines_out = in_hold ? dma_rdata_r : wdata_r;
    assign data_lines_oe = (bus_on && cyc && write_r && state_r != EMBI_ADDR)
        || (off_n_s && dma_drive_r);

    assign program_space_select_n = !(cyc && space_r == EMBI_SP_PROG);
    assign data_space_select_n = !(cyc && (space_r == EMBI_SP_DATA || space_r == EMBI_SP_GLOBAL));
    assign io_space_select_n = !(cyc && space_r == EMBI_SP_IO);
    assign space_select_oe = bus_on;

    assign read_write_out = !(cyc && write_r);
    assign read_write_oe = bus_on;

    assign bus_cycle_strobe_n_out = !(state_r == EMBI_STROBE);
    assign bus_cycle_strobe_n_oe = bus_on;

    assign read_select_n = !(state_r == EMBI_STROBE && !write_r);
    assign read_select_n_oe = bus_on;

    assign write_enable_n = !(state_r == EMBI_STROBE && write_r);
    assign write_enable_n_oe = bus_on;

    assign bus_request_n_out = !(cyc && space_r == EMBI_SP_GLOBAL);
    assign bus_request_n_oe = bus_on;
endmodule : embi_bus

// ==== embi_pkg.sv ====
// Constants and types shared by the external memory bus interface.
package embi_pkg;
    localparam int EMBI_AW = 16;
    localparam int EMBI_DW = 16;
    localparam int EMBI_RAM_WORDS = 9216;
    localparam int EMBI_RAM_AW = 14;
    localparam int EMBI_SYNC_STAGES = 3;
    localparam logic [1:0] EMBI_SP_PROG = 2'h0;
    localparam logic [1:0] EMBI_SP_DATA = 2'h1;
    localparam logic [1:0] EMBI_SP_IO = 2'h2;
    localparam logic [1:0] EMBI_SP_GLOBAL = 2'h3;
    localparam logic [EMBI_DW-1:0] EMBI_DATA_RST = 16'h0000;
    localparam logic [EMBI_AW-1:0] EMBI_ADDR_RST = 16'h0000;
    typedef enum logic [2:0] {EMBI_IDLE, EMBI_ADDR, EMBI_STROBE, EMBI_DONE, EMBI_HOLD} embi_state_t;
endpackage : embi_pkg

// ==== embi_sync.sv ====
// Three-stage synchroniser with agreement of the last two stages.
module embi_sync
    import embi_pkg::*;
#(
    parameter logic RST_VAL = 1'b1
)
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic din,
    output logic dout
);
    logic [EMBI_SYNC_STAGES-1:0] sh_r;
    logic [EMBI_SYNC_STAGES-1:0] sh_nxt;
    logic out_r;
    logic out_nxt;

    always_comb
    begin
        sh_nxt = {sh_r[EMBI_SYNC_STAGES-2:0], din};
        out_nxt = out_r;
        // The level changes only once the second and third stages agree.
        if (sh_r[1] == sh_r[2])
        begin
            out_nxt = sh_r[2];
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            sh_r <= {EMBI_SYNC_STAGES{RST_VAL}};
            out_r <= RST_VAL;
        end
        else
        begin
            sh_r <= sh_nxt;
            out_r <= out_nxt;
        end
    end

    assign dout = out_r;
endmodule : embi_sync

// ==== embi_bus_properties.sv ====
// Port-level checks for the external memory bus interface.
module embi_bus_chk
    import embi_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic ready_in,
    input wire logic hold_acknowledge_n,
    input wire logic [EMBI_AW-1:0] address_lines_out,
    input wire logic address_lines_oe,
    input wire logic data_lines_oe,
    input wire logic program_space_select_n,
    input wire logic data_space_select_n,
    input wire logic io_space_select_n,
    input wire logic space_select_oe,
    input wire logic read_write_out,
    input wire logic bus_cycle_strobe_n_out,
    input wire logic read_select_n,
    input wire logic write_enable_n,
    input wire logic bus_request_n_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);
    sequence s_take;
        req_valid && req_ready;
    endsequence
    sequence s_in_wait;
        !bus_cycle_strobe_n_out && $past(!bus_cycle_strobe_n_out);
    endsequence
    a_cycle_ends: assert property (s_take |-> ##[3:40] rsp_valid)
        else $error("bus cycle did not finish");
    a_ready_seen: assert property (rsp_valid |-> $past(ready_in, 2) || $past(ready_in, 3) ||
        $past(ready_in, 4) || $past(ready_in, 5) || $past(ready_in, 6)) else $error("finished without ready");
    a_hold_float: assert property (!hold_acknowledge_n |-> !address_lines_oe && !space_select_oe)
        else $error("bus driven in hold");
    a_write_drive: assert property (!write_enable_n |-> !read_write_out && data_lines_oe)
        else $error("write without drive");
    a_read_float: assert property (!read_select_n |-> read_write_out && !data_lines_oe)
        else $error("read with data driven");
    a_one_space: assert property ($onehot0(~{program_space_select_n, data_space_select_n, io_space_select_n}))
        else $error("two spaces selected");
    a_wait_stable: assert property (s_in_wait |-> $stable(address_lines_out) && $stable(read_write_out))
        else $error("address moved in wait");
    a_global_req: assert property (!bus_request_n_out |-> !data_space_select_n)
        else $error("request outside data space");
    a_idle_strobe: assert property (req_ready |-> bus_cycle_strobe_n_out && read_select_n)
        else $error("strobe low while idle");
endmodule : embi_bus_chk

bind embi_bus embi_bus_chk u_chk (.*);

// ==== embi_mem_model.sv ====
// External memory with a chosen number of wait cycles.
module embi_mem_model
(
    input wire logic clock,
    input wire logic strobe_n,
    input wire logic rd_n,
    input wire logic we_n,
    input wire logic [15:0] addr,
    input wire logic [15:0] wdata,
    input wire logic [1:0] waits,
    output logic ready,
    output logic [15:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [16];
    logic [15:0] last = 16'h0000;
    int cnt = 0;
    always @(posedge clock)
    begin
        cnt <= strobe_n ? 0 : cnt + 1;
        if (!we_n)
            mem[addr[3:0]] <= wdata;
        if (!rd_n)
            last <= mem[addr[3:0]];
    end
    assign ready = !strobe_n && (cnt >= waits);
    // An unselected part leaves the inverse of the last word so stale data cannot pass.
    assign rdata = !rd_n ? mem[addr[3:0]] : ~last;
endmodule : embi_mem_model

// ==== embi_bus_tb_top.sv ====
// Self-checking bench for the external memory bus interface.
module embi_bus_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import embi_pkg::*;
    typedef struct {logic [1:0] sp; logic [15:0] ad; logic [15:0] wd; logic [1:0] wt; logic [3:0] sel;} embi_row_t;
    embi_row_t rows [4] = '{'{EMBI_SP_PROG, 16'h1231, 16'ha5a5, 2'h0, 4'h7},
        '{EMBI_SP_DATA, 16'h0042, 16'h5a5a, 2'h1, 4'hb}, '{EMBI_SP_IO, 16'h0f03, 16'h1234, 2'h2, 4'hd},
        '{EMBI_SP_GLOBAL, 16'h8004, 16'hbeef, 2'h3, 4'ha}};
    logic clock, rstn, req_valid, req_ready, req_write, rsp_valid, instruction_acquire_n, output_off_n;
    logic hold_request_n, ready_in, hold_acknowledge_n, hold_acknowledge_n_oe, address_lines_oe, data_lines_oe;
    logic program_space_select_n, data_space_select_n, io_space_select_n, space_select_oe, read_write_in;
    logic read_write_out, read_write_oe, bus_cycle_strobe_n_in, bus_cycle_strobe_n_out, bus_cycle_strobe_n_oe;
    logic read_select_n, read_select_n_oe, write_enable_n, write_enable_n_oe, bus_request_n_in;
    logic bus_request_n_out, bus_request_n_oe;
    logic seen_clr, dma_drive;
    logic [15:0] dma_data;
    logic [1:0] req_space, waits;
    logic [3:0] seen;
    logic [15:0] req_addr, req_wdata, rsp_rdata, address_lines_in, address_lines_out, data_lines_out, mem_rdata;
    wire logic [15:0] data_lines_in = data_lines_oe ? data_lines_out : dma_drive ? dma_data : mem_rdata;
    int n_mismatch = 0;
    int n_checks = 0;
    embi_bus dut (.*);
    embi_mem_model mem (.clock(clock), .strobe_n(bus_cycle_strobe_n_out), .rd_n(read_select_n),
        .we_n(write_enable_n), .addr(address_lines_out), .wdata(data_lines_out), .waits(waits),
        .ready(ready_in), .rdata(mem_rdata));
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(posedge clock)
        seen <= seen_clr ? 4'hf : seen & {program_space_select_n, data_space_select_n, io_space_select_n, bus_request_n_out};
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out
    task automatic wait_for(ref logic s, input logic v);
        for (int i = 0; i < 60 && s !== v; i++)
            @(negedge clock);
        if (s !== v)
        begin
            n_mismatch++;
            close_out();
        end
    endtask : wait_for
    task automatic access(input embi_row_t r, input logic wr);
        wait_for(req_ready, 1'b1);
        {req_space, req_write, req_addr, req_wdata, waits} = {r.sp, wr, r.ad, r.wd, r.wt};
        {req_valid, seen_clr} = 2'b11;
        @(negedge clock);
        {req_valid, seen_clr} = 2'b00;
        wait_for(rsp_valid, 1'b1);
    endtask : access
    initial
    begin
        {req_valid, req_write, req_space, req_addr, req_wdata, waits, address_lines_in, dma_drive, dma_data, rstn} = '0;
        {instruction_acquire_n, read_write_in, bus_cycle_strobe_n_in, bus_request_n_in} = 4'hf;
        {output_off_n, hold_request_n, seen_clr} = 3'h7;
        repeat (6) @(negedge clock);
        chk(16'(bus_cycle_strobe_n_out), 16'h0001);
        chk(16'(data_lines_oe), 16'h0000);
        rstn = 1'b1;
        for (int p = 0; p < 2; p++)
            for (int k = 0; k < 4; k++)
            begin
                access(rows[k], p == 0);
                chk(16'(seen), 16'(rows[k].sel));
                chk(address_lines_out, rows[k].ad);
                if (p == 1)
                    chk(rsp_rdata, rows[k].wd);
            end
        hold_request_n = 1'b0;
        wait_for(hold_acknowledge_n, 1'b0);
        chk(16'({req_ready, address_lines_oe, data_lines_oe, read_write_oe, bus_cycle_strobe_n_oe}), 16'h0000);
        {bus_request_n_in, instruction_acquire_n, read_write_in, dma_drive} = 4'h1;
        {address_lines_in, dma_data} = {16'h0005, 16'hc3c3};
        for (int d = 0; d < 2; d++)
        begin
            repeat (5) @(negedge clock);
            bus_cycle_strobe_n_in = 1'b0;
            repeat (6) @(negedge clock);
            chk(16'(data_lines_oe), 16'(d));
            if (d == 1)
                chk(data_lines_out, 16'hc3c3);
            bus_cycle_strobe_n_in = 1'b1;
            {read_write_in, dma_drive} = 2'b10;
        end
        repeat (6) @(negedge clock);
        chk(16'(data_lines_oe), 16'h0000);
        {bus_request_n_in, instruction_acquire_n} = 2'b11;
        hold_request_n = 1'b1;
        wait_for(hold_acknowledge_n, 1'b1);
        output_off_n = 1'b0;
        wait_for(address_lines_oe, 1'b0);
        chk(16'({space_select_oe, read_select_n_oe, write_enable_n_oe, bus_request_n_oe, hold_acknowledge_n_oe}), 16'h0000);
        output_off_n = 1'b1;
        wait_for(address_lines_oe, 1'b1);
        access(rows[3], 1'b0);
        chk(rsp_rdata, rows[3].wd);
        close_out();
    end
endmodule : embi_bus_tb_top
